// ---- rtl/fsc_bus_cycle.sv ----
`timescale 1ns/10ps
`default_nettype none
// one timed write or read cycle on the flash pins
module fsc_bus_cycle
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic start,
  input wire fsc_pkg::fsc_cycle_t req,
  input wire logic [7:0] dq_in,
  output logic done,
  output logic [7:0] rd_data,
  output logic ce_n,
  output logic we_n,
  output logic oe_n,
  output logic [fsc_pkg::ADDR_W-1:0] addr,
  output logic [7:0] dq_out,
  output logic dq_oe
);

  typedef enum logic [1:0]
  {
    BC_IDLE = 2'b00,
    BC_STROBE = 2'b01,
    BC_HOLD = 2'b11
  } fsc_bc_state_t;

  fsc_bc_state_t state;
  logic [4:0] count;
  logic is_write;

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      state <= BC_IDLE;
      count <= 5'h00;
      is_write <= 1'b0;
      ce_n <= 1'b1;
      we_n <= 1'b1;
      oe_n <= 1'b1;
      addr <= '0;
      dq_out <= 8'h00;
      dq_oe <= 1'b0;
      rd_data <= 8'h00;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      case (state)
        BC_IDLE:
        begin
          if (start)
          begin
            is_write <= req.we;
            addr <= req.addr;
            dq_out <= req.data;
            dq_oe <= req.we;
            ce_n <= 1'b0;
            we_n <= ~req.we;
            oe_n <= ~req.oe;
            count <= req.we ? fsc_pkg::WE_LOW_CYC : fsc_pkg::OE_CYC;
            state <= BC_STROBE;
          end
        end
        BC_STROBE:
        begin
          if (count > 5'h01)
          begin
            count <= count - 5'h01;
          end
          else
          begin
            // data latched on rising we, status latched while oe low
            if (!is_write)
            begin
              rd_data <= dq_in;
            end
            we_n <= 1'b1;
            oe_n <= 1'b1;
            ce_n <= 1'b1;
            count <= is_write ? fsc_pkg::WE_HIGH_CYC : fsc_pkg::REC_CYC;
            state <= BC_HOLD;
          end
        end
        BC_HOLD:
        begin
          if (count > 5'h01)
          begin
            count <= count - 5'h01;
          end
          else
          begin
            dq_oe <= 1'b0;
            done <= 1'b1;
            state <= BC_IDLE;
          end
        end
        default:
        begin
          state <= BC_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ---- rtl/fsc_host.sv ----
`timescale 1ns/10ps
`default_nettype none
// Contract
// - bits 5 and 4 mean bad sequence
// - host masks reserved status bits
// - clear status uses code 50h
// - clear only when idle or suspended
// - errors accumulate across several operations
// - erase is setup then confirm, block address
// - poll bit 7, toggle oe per read
// - check bit 5, clear before correction
module fsc_host
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic cmd_valid,
  input wire fsc_pkg::fsc_op_t cmd_op,
  input wire logic [fsc_pkg::ADDR_W-1:0] cmd_addr,
  output logic cmd_ready,
  output logic done,
  output fsc_pkg::fsc_result_t result,
  output logic [7:0] status_raw,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n,
  output logic [fsc_pkg::ADDR_W-1:0] flash_addr,
  input wire logic [7:0] flash_dq_in,
  output logic [7:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic status_output_pin
);

  typedef enum logic [2:0]
  {
    HS_IDLE = 3'b000,
    HS_SETUP = 3'b001,
    HS_CONFIRM = 3'b011,
    HS_POLL = 3'b010,
    HS_CHECK = 3'b110,
    HS_XSR = 3'b111,
    HS_CLEAR = 3'b101
  } fsc_host_state_t;

  fsc_host_state_t state;
  fsc_pkg::fsc_op_t op;
  logic [fsc_pkg::ADDR_W-1:0] block_addr;
  logic cyc_start;
  fsc_pkg::fsc_cycle_t cyc_req;
  logic cyc_done;
  logic [7:0] cyc_data;
  logic [7:0] sr_masked;

  fsc_bus_cycle u_cycle
  (
    .sys_clk(sys_clk),
    .reset(reset),
    .start(cyc_start),
    .req(cyc_req),
    .dq_in(flash_dq_in),
    .done(cyc_done),
    .rd_data(cyc_data),
    .ce_n(flash_ce_n),
    .we_n(flash_we_n),
    .oe_n(flash_oe_n),
    .addr(flash_addr),
    .dq_out(flash_dq_out),
    .dq_oe(flash_dq_oe)
  );

  assign sr_masked = cyc_data & fsc_pkg::SR_VALID_MASK;
  assign cmd_ready = (state == HS_IDLE) && !cyc_start;

  // one pin cycle issued per state entry, reissued after each done while in HS_POLL
  always_comb
  begin
    cyc_req.we = 1'b0;
    cyc_req.oe = 1'b1;
    cyc_req.addr = block_addr;
    cyc_req.data = 8'h00;
    case (state)
      HS_SETUP:
      begin
        cyc_req.we = 1'b1;
        cyc_req.oe = 1'b0;
        cyc_req.data = fsc_pkg::CMD_ERASE_SETUP;
      end
      HS_CONFIRM:
      begin
        cyc_req.we = 1'b1;
        cyc_req.oe = 1'b0;
        cyc_req.data = fsc_pkg::CMD_ERASE_CONFIRM;
      end
      HS_CLEAR:
      begin
        cyc_req.we = 1'b1;
        cyc_req.oe = 1'b0;
        cyc_req.data = fsc_pkg::CMD_CLEAR_STATUS;
      end
      HS_XSR:
      begin
        cyc_req.we = 1'b1;
        cyc_req.oe = 1'b0;
        cyc_req.data = fsc_pkg::CMD_READ_STATUS;
      end
      default:
      begin
        cyc_req.we = 1'b0;
        cyc_req.oe = 1'b1;
      end
    endcase
  end

  logic issued;

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      issued <= 1'b0;
    end
    else if (cyc_done || state == HS_IDLE)
    begin
      issued <= 1'b0;
    end
    else
    begin
      issued <= 1'b1;
    end
  end

  assign cyc_start = (state != HS_IDLE) && !issued;

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      state <= HS_IDLE;
      op <= fsc_pkg::OP_STATUS;
      block_addr <= '0;
      done <= 1'b0;
      result <= '0;
      status_raw <= 8'h00;
    end
    else
    begin
      done <= 1'b0;
      case (state)
        HS_IDLE:
        begin
          if (cmd_valid)
          begin
            op <= cmd_op;
            block_addr <= cmd_addr;
            case (cmd_op)
              fsc_pkg::OP_ERASE: state <= HS_SETUP;
              fsc_pkg::OP_CLEAR: state <= HS_POLL;
              default: state <= HS_POLL;
            endcase
          end
        end
        HS_SETUP:
        begin
          if (cyc_done)
          begin
            state <= HS_CONFIRM;
          end
        end
        HS_CONFIRM:
        begin
          if (cyc_done)
          begin
            state <= HS_POLL;
          end
        end
        HS_POLL:
        begin
          // each poll is a fresh oe strobe, refreshing the latch
          if (cyc_done && (cyc_data[fsc_pkg::SR_READY] ||
              status_output_pin))
          begin
            state <= (op == fsc_pkg::OP_CLEAR) ? HS_CLEAR : HS_CHECK;
          end
          else if (cyc_done && op == fsc_pkg::OP_CLEAR)
          begin
            state <= HS_POLL;
          end
        end
        HS_CHECK:
        begin
          if (cyc_done)
          begin
            // full register re-read once ready
            status_raw <= sr_masked;
            result.ready <= sr_masked[fsc_pkg::SR_READY];
            result.erase_suspended <= sr_masked[fsc_pkg::SR_ERASE_SUSP];
            result.erase_error <= sr_masked[fsc_pkg::SR_ERASE_ERR];
            result.program_error <= sr_masked[fsc_pkg::SR_PROG_ERR];
            result.low_voltage <= sr_masked[fsc_pkg::SR_LOW_VPP];
            result.program_suspended <= sr_masked[fsc_pkg::SR_PROG_SUSP];
            result.locked_abort <= sr_masked[fsc_pkg::SR_LOCKED];
            result.bad_sequence <= sr_masked[fsc_pkg::SR_ERASE_ERR] &
              sr_masked[fsc_pkg::SR_PROG_ERR];
            result.buffer_free <= 1'b0;
            state <= HS_XSR;
          end
        end
        HS_XSR:
        begin
          // leaves device in status mode; results held until next op
          if (cyc_done)
          begin
            result.buffer_free <= cyc_data[fsc_pkg::XSR_BUF_FREE] &
              fsc_pkg::XSR_VALID_MASK[fsc_pkg::XSR_BUF_FREE];
            done <= 1'b1;
            state <= HS_IDLE;
          end
        end
        HS_CLEAR:
        begin
          if (cyc_done)
          begin
            result <= '0;
            status_raw <= 8'h00;
            done <= 1'b1;
            state <= HS_IDLE;
          end
        end
        default:
        begin
          state <= HS_IDLE;
        end
      endcase
    end
  end

  // erase leaves ffh in the block; verifying it is left to array reads

endmodule
`default_nettype wire

// ---- rtl/fsc_pkg.sv ----
package fsc_pkg;

  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hd0;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  localparam int SR_READY = 7;
  localparam int SR_ERASE_SUSP = 6;
  localparam int SR_ERASE_ERR = 5;
  localparam int SR_PROG_ERR = 4;
  localparam int SR_LOW_VPP = 3;
  localparam int SR_PROG_SUSP = 2;
  localparam int SR_LOCKED = 1;
  localparam int XSR_BUF_FREE = 7;
  localparam logic [7:0] SR_VALID_MASK = 8'hfe;
  localparam logic [7:0] XSR_VALID_MASK = 8'h80;

  localparam int ADDR_W = 24;
  localparam int CLK_NS = 10;
  localparam int T_WE_LOW_NS = 70;
  localparam int T_WE_HIGH_NS = 30;
  localparam int T_OE_ACCESS_NS = 120;
  localparam int T_RECOVER_NS = 30;
  localparam logic [4:0] WE_LOW_CYC = 5'((T_WE_LOW_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [4:0] WE_HIGH_CYC =
    5'((T_WE_HIGH_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [4:0] OE_CYC = 5'((T_OE_ACCESS_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [4:0] REC_CYC = 5'((T_RECOVER_NS + CLK_NS - 1) / CLK_NS);

  typedef enum logic [1:0]
  {
    OP_ERASE = 2'h0,
    OP_CLEAR = 2'h1,
    OP_STATUS = 2'h2
  } fsc_op_t;

  typedef struct packed
  {
    logic ready;
    logic erase_suspended;
    logic erase_error;
    logic program_error;
    logic low_voltage;
    logic program_suspended;
    logic locked_abort;
    logic bad_sequence;
    logic buffer_free;
  } fsc_result_t;

  typedef struct packed
  {
    logic we;
    logic oe;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
  } fsc_cycle_t;

endpackage

// ---- verification/fsc_flash_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module fsc_flash_model
(
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic [7:0] din,
  input wire logic lock,
  input wire logic low_v,
  input wire logic bad,
  output logic [7:0] dout,
  output logic sts
);
  logic [7:0] sr = 8'h80;
  logic [7:0] cmd = 8'hff;
  logic [7:0] lat = 8'h00;
  int busy = 0;
  int erases = 0;
  logic wr_n;
  logic rd_n;
  // whichever strobe ends the write first latches it, as on the real pins
  assign wr_n = we_n | ce_n;
  assign rd_n = oe_n | ce_n;
  always @(posedge wr_n)
    begin
      if (cmd == 8'h20 && (din != 8'hd0 || bad))
        sr[5:4] = 2'b11;
      else if (cmd == 8'h20)
      begin
        sr[5] = sr[5] | lock | low_v;
        sr[3] = sr[3] | low_v;
        sr[1] = sr[1] | lock;
        if (!lock && !low_v)
        begin
          busy = 4;
          erases++;
        end
      end
      if (din == 8'h50)
        sr = sr & 8'hc5;
      cmd = (cmd == 8'h20) ? 8'h70 : din;
    end
  // status latched at each output-enable fall
  always @(negedge rd_n)
    begin
      if (busy > 0)
        busy--;
      sr[7] = (busy == 0);
      if (busy > 0)
        lat = {1'b0, ~lat[6:0]};
      else
        lat = (cmd == 8'hff) ? fsc_pkg::ERASED_BYTE : sr;
    end
  assign sts = (busy == 0);
  assign dout = (oe_n || ce_n) ? ~lat : lat;
endmodule
`default_nettype wire

// ---- verification/fsc_host_properties.sv ----
`timescale 1ns/10ps
`default_nettype none
module fsc_host_properties
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic cmd_valid,
  input wire fsc_pkg::fsc_op_t cmd_op,
  input wire logic cmd_ready,
  input wire logic done,
  input wire fsc_pkg::fsc_result_t result,
  input wire logic [7:0] status_raw,
  input wire logic flash_ce_n,
  input wire logic flash_we_n,
  input wire logic flash_oe_n,
  input wire logic flash_dq_oe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_done_pulse: assert property (done |=> !done)
    else $error("done longer than one cycle");
  a_take_busy: assert property (cmd_valid && cmd_ready |=> !cmd_ready)
    else $error("ready stayed high after take");
  a_bit0_masked: assert property (done |-> !status_raw[0])
    else $error("reserved bit not masked");
  a_bad_decode: assert property
    (done |-> result.bad_sequence == (status_raw[5] && status_raw[4]))
    else $error("bad sequence decode wrong");
  a_lock_err: assert property
    (done && result.locked_abort |-> status_raw[1] && status_raw[5])
    else $error("locked abort without status bits");
  a_we_width: assert property
    ($fell(flash_we_n) |-> !flash_we_n [*7] ##1 flash_we_n)
    else $error("write strobe width wrong");
  a_we_drives: assert property
    (!flash_we_n |-> flash_dq_oe && !flash_ce_n)
    else $error("write without data drive");
  a_oe_float: assert property (!flash_oe_n |-> !flash_dq_oe && !flash_ce_n)
    else $error("bus contention on read");
  a_oe_toggle: assert property ($fell(flash_oe_n) |-> !flash_oe_n [*8])
    else $error("read strobe too short");
  a_erase_bound: assert property
    (cmd_valid && cmd_ready && cmd_op == fsc_pkg::OP_ERASE |-> ##[40:1000] done)
    else $error("erase did not finish");
  c_erase_err: cover property (done && result.erase_error);
  c_bad_seq: cover property (done && result.bad_sequence);
  c_low_v: cover property (done && result.low_voltage);
endmodule
bind fsc_host fsc_host_properties u_props
(
  .sys_clk, .reset, .cmd_valid, .cmd_op, .cmd_ready, .done, .result,
  .status_raw, .flash_ce_n, .flash_we_n, .flash_oe_n, .flash_dq_oe
);
`default_nettype wire

// ---- verification/fsc_host_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module fsc_host_tb;
  // op, lock, low voltage, bad confirm, expected result
  typedef struct packed
  {
    fsc_pkg::fsc_op_t op;
    logic lk;
    logic lv;
    logic bd;
    logic [8:0] ex;
  } fsc_row_t;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic cmd_valid = 1'b0;
  fsc_pkg::fsc_op_t cmd_op = fsc_pkg::OP_STATUS;
  logic lk = 1'b0;
  logic lv = 1'b0;
  logic bd = 1'b0;
  logic cmd_ready, done, ce_n, we_n, oe_n, dq_oe, sts;
  logic [7:0] status_raw, dq_o, dq_i;
  logic [23:0] addr;
  fsc_pkg::fsc_result_t result;
  int fail_count = 0;
  int n_compared = 0;
  fsc_row_t rows [10];
  fsc_host uut
  (
    .sys_clk(sys_clk), .reset(reset), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_addr(24'h020000), .cmd_ready(cmd_ready),
    .done(done), .result(result), .status_raw(status_raw),
    .flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n),
    .flash_addr(addr), .flash_dq_in(dq_i), .flash_dq_out(dq_o),
    .flash_dq_oe(dq_oe), .status_output_pin(sts)
  );
  fsc_flash_model flash
  (
    .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .din(dq_o), .lock(lk),
    .low_v(lv), .bad(bd), .dout(dq_i), .sts(sts)
  );
  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic close_out;
    $display("compared %0d, failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic ok);
    n_compared++;
    if (ok !== 1'b1)
    begin
      fail_count++;
      $display("ERROR %0t: output mismatch", $time);
    end
  endtask
  task automatic run(input fsc_pkg::fsc_op_t op);
    int i;
    @(posedge sys_clk);
    #1;
    cmd_valid = 1'b1;
    cmd_op = op;
    @(posedge sys_clk);
    #1;
    cmd_valid = 1'b0;
    for (i = 0; i < 3000 && done !== 1'b1; i++)
    begin
      @(posedge sys_clk);
      #1;
    end
    check(done === 1'b1);
  endtask
  initial
  begin
    #500000;
    fail_count++;
    close_out();
  end
  initial
  begin
    rows = '{14'h0000, 14'h0844, 14'h0044, 14'h2044, 14'h1000,
      14'h0450, 14'h0854, 14'h1000, 14'h0262, 14'h1000};
    repeat (10) @(posedge sys_clk);
    #1;
    reset = 1'b0;
    foreach (rows[k])
    begin
      lk = rows[k].lk;
      lv = rows[k].lv;
      bd = rows[k].bd;
      run(rows[k].op);
      check((result & 9'h0fe) === (rows[k].ex & 9'h0fe));
      check(rows[k].op == fsc_pkg::OP_CLEAR || result.ready === 1'b1);
      check(status_raw === (rows[k].op == fsc_pkg::OP_CLEAR ? 8'h00 :
        {1'b1, rows[k].ex[7:2], 1'b0}));
    end
    @(posedge sys_clk);
    #1;
    cmd_valid = 1'b1;
    cmd_op = fsc_pkg::OP_ERASE;
    repeat (5) @(posedge sys_clk);
    #1;
    cmd_valid = 1'b0;
    reset = 1'b1;
    #1;
    check({cmd_ready, done, we_n, ce_n, dq_oe, result} === 14'h2c00);
    repeat (3) @(posedge sys_clk);
    #1;
    reset = 1'b0;
    run(fsc_pkg::OP_CLEAR);
    check(result.erase_error === 1'b0);
    run(fsc_pkg::OP_ERASE);
    check((result & 9'h0fe) === 9'h000);
    check(flash.erases == 3);
    check(flash.cmd === 8'h70);
    check(addr === 24'h020000);
    close_out();
  end
endmodule
`default_nettype wire
